// File: include/rmw_breakpoint_request_pin_defines.svh
// Constants for the indivisible-cycle and processor-space bus sequencer.
// Assumes one core clock; each full bus state pair S(2n)/S(2n+1) spans one clock.
//
// Overview of operation
// [RL1] Indivisible-cycle flag stays asserted through the whole read-modify-write sequence.
// [RL2] No bus grant is issued while the indivisible sequence runs.
// [RL3] Read S0: flag, address, function code, size valid, direction high.
// [RL4] Read S1: address strobe and data strobe asserted together.
// [RL5] Responder picks byte lanes from size code and two low address bits; bus_responder ignores both and moves the whole 32-bit word.
// [RL6] Acknowledge by end of S2 latches data next; else wait states until seen.
// [RL7] Responder keeps both acknowledges negated around S2 end to get waits.
// [RL8] Read data latched at end of S4; strobes negated during S5.
// [RL9] Several reads repeat S0-S5; address, direction, code held for write.
// [RL10] Responder drops data and acknowledge within about a clock after strobes fall.
// [RL11] Idle states add no control; write skipped if unneeded; data undriven until S2.
// [RL12] Write S0 drives direction low, address may change; S1 asserts address strobe.
// [RL13] Write S2 drives all 32 data lines; S3 asserts data strobe.
// [RL14] Write acknowledge by end of S2 ends cycle a clock later; else wait states.
// [RL15] Write S5 negates strobes, holds address and data; repeats per further write.
// [RL16] Responder latches selected lanes and acknowledges once data is stored; bus_responder latches the whole word and acknowledges after wait_cycles clocks.
// [RL17] Processor-space cycles use function code 7, type on address bits 19-16.
// [RL18] Software breakpoint: type-0 word read, number on bits 4-2, bit 1 clear.
// [RL19] Soft breakpoint: bus error gives illegal trap; acknowledge returns upper 16 data bits.
// [RL20] Hardware breakpoint: bits 4-2 ones, bit 1 set; error traps, acknowledge continues.
// [RL21] Breakpoint pin sampled with data; requester holds it until acknowledge cycle.
// [RL22] Paired fetch: breakpoint taken after first instruction, before second.
// [RL23] Acknowledge pair sampled at data latch gives responder port width.
// [RL24] Acknowledge, bus error and breakpoint inputs are synchronised before use.
`ifndef RMW_BREAKPOINT_REQUEST_PIN_DEFINES_SVH
`define RMW_BREAKPOINT_REQUEST_PIN_DEFINES_SVH
`define FC_PROC_SPACE     4'h7
`define PSP_TYPE_BREAKPOINT_REQUEST_PIN     4'h0
`define PSP_TYPE_LSB      16
`define BREAKPOINT_REQUEST_PIN_NUM_LSB      2
`define BREAKPOINT_REQUEST_PIN_TBIT         1
`define BREAKPOINT_REQUEST_PIN_HW_NUM       3'h7
`define SIZE_WORD         2'h2
`define SYNC_STAGES       2
`endif

// File: include/rmw_breakpoint_request_pin_pkg.sv
// Types shared by the bus sequencer.
// Assumes the defines header is compiled alongside.
package rmw_breakpoint_request_pin_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_S0    = 4'h1,
        ST_S2    = 4'h2,
        ST_WAIT  = 4'h3,
        ST_S4    = 4'h4,
        ST_GAP   = 4'h5,
        ST_DONE  = 4'h6
    } bus_state_t;

    typedef enum logic [1:0] {
        OP_RMW   = 2'h0,
        OP_SWBK  = 2'h1,
        OP_HWBK  = 2'h2
    } op_kind_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0]  fc;
        logic [1:0]  size;
    } bus_addr_t;

    typedef struct packed {
        logic        bus_err;
        logic        illegal_trap;
        logic        breakpoint_request_pin_trap;
        logic [15:0] opword;
        logic [1:0]  port_width;
    } bus_result_t;
endpackage

// File: core/rmw_breakpoint_request_pin_seq.sv
// Bus-master sequencer for indivisible read-modify-write and breakpoint cycles.
// Assumes acknowledge, bus error and breakpoint pins are asynchronous, active high internally.
`include "rmw_breakpoint_request_pin_defines.svh"
module rmw_breakpoint_request_pin_seq
    import rmw_breakpoint_request_pin_pkg::*;
#(
    parameter int MAX_XFERS = 4
) (
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              op_start,
    input  wire op_kind_t          op_kind,
    input  wire bus_addr_t         op_addr,
    input  wire logic [31:0]       op_wdata,
    input  wire logic [2:0]        op_reads,
    input  wire logic [2:0]        op_writes,
    input  wire logic [2:0]        op_breakpoint_request_pin_num,
    input  wire logic              op_pair_fetch,
    input  wire logic              bus_request_in,
    input  wire logic              transfer_ack_high,
    input  wire logic              transfer_ack_low,
    input  wire logic              bus_error_in,
    input  wire logic              breakpoint_request_pin,
    input  wire logic [31:0]       data_in,
    output logic                   op_busy,
    output logic                   op_done,
    output bus_result_t            op_result,
    output logic [31:0]            op_rdata,
    output logic                   breakpoint_request_pin_pending,
    output logic                   breakpoint_request_pin_after_first,
    output logic                   bus_grant_out,
    output logic                   indivisible_cycle_flag,
    output logic                   address_strobe,
    output logic                   data_strobe,
    output logic                   read_not_write,
    output bus_addr_t              bus_addr,
    output logic [31:0]            data_out,
    output logic                   data_oe_n
);
    initial begin
        if (MAX_XFERS < 1 || MAX_XFERS > 7) begin
            $error("MAX_XFERS must be 1 to 7.");
        end
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
        end else begin
            sync1_ff <= {breakpoint_request_pin, bus_error_in,
                         transfer_ack_high, transfer_ack_low}; // RL24
            sync2_ff <= sync1_ff;
        end
    end
    logic ack_s;
    logic bus_error_in_s;
    logic breakpoint_request_pin_s;
    assign ack_s  = sync2_ff[0] | sync2_ff[1]; // RL6
    assign bus_error_in_s = sync2_ff[2];
    assign breakpoint_request_pin_s = sync2_ff[3];

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    bus_state_t state_ff;
    op_kind_t   kind_ff;
    logic       writing_ff;
    logic [2:0] reads_left_ff;
    logic [2:0] writes_left_ff;
    logic       term_ok;
    assign term_ok = ack_s | bus_error_in_s;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff       <= ST_IDLE;
            kind_ff        <= OP_RMW;
            writing_ff     <= 1'b0;
            reads_left_ff  <= 3'h0;
            writes_left_ff <= 3'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (op_start) begin
                        state_ff       <= ST_S0;
                        kind_ff        <= op_kind;
                        writing_ff     <= 1'b0;
                        reads_left_ff  <= (op_kind == OP_RMW) ? op_reads : 3'h1;
                        writes_left_ff <= (op_kind == OP_RMW) ? op_writes : 3'h0;
                    end
                end
                ST_S0: state_ff <= ST_S2;
                ST_S2: state_ff <= term_ok ? ST_S4 : ST_WAIT; // RL6 RL14
                ST_WAIT: begin
                    if (term_ok) begin
                        state_ff <= ST_S4; // RL6 RL14
                    end
                end
                ST_S4: begin
                    if (!writing_ff && reads_left_ff > 3'h1 && !bus_error_in_s) begin
                        reads_left_ff <= reads_left_ff - 3'h1; // RL9
                        state_ff      <= ST_S0;
                    end else if (writing_ff && writes_left_ff > 3'h1 && !bus_error_in_s) begin
                        writes_left_ff <= writes_left_ff - 3'h1; // RL15
                        state_ff       <= ST_S0;
                    end else if (!writing_ff && writes_left_ff != 3'h0 && !bus_error_in_s) begin
                        state_ff <= ST_GAP; // RL11
                    end else begin
                        state_ff <= ST_DONE; // RL11
                    end
                end
                ST_GAP: begin
                    writing_ff <= 1'b1;
                    state_ff   <= ST_S0;
                end
                ST_DONE: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    logic bus_on;
    assign bus_on = (state_ff == ST_S2) || (state_ff == ST_WAIT) || (state_ff == ST_S4);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            address_strobe <= 1'b0;
            data_strobe    <= 1'b0;
        end else begin
            address_strobe <= (state_ff == ST_S0) ||
                              ((state_ff == ST_S2 || state_ff == ST_WAIT) && !term_ok); // RL4 RL12
            data_strobe    <= (state_ff == ST_S0 && !writing_ff) ||
                              (state_ff == ST_S2 && writing_ff && !term_ok) ||
                              (state_ff == ST_S2 && !writing_ff && !term_ok) ||
                              (state_ff == ST_WAIT && !term_ok); // RL4 RL8 RL13 RL15
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            indivisible_cycle_flag <= 1'b0;
            read_not_write         <= 1'b1;
            bus_addr               <= '0;
            data_out               <= 32'h0;
            data_oe_n              <= 1'b1;
        end else begin
            if (state_ff == ST_IDLE && op_start) begin
                indivisible_cycle_flag <= (op_kind == OP_RMW); // RL1 RL3
                read_not_write         <= 1'b1; // RL3
                data_out               <= op_wdata;
                if (op_kind == OP_RMW) begin
                    bus_addr <= op_addr;
                end else begin
                    bus_addr.fc   <= `FC_PROC_SPACE; // RL17
                    bus_addr.size <= `SIZE_WORD;
                    bus_addr.addr <= 32'h0;
                    bus_addr.addr[`PSP_TYPE_LSB +: 4] <= `PSP_TYPE_BREAKPOINT_REQUEST_PIN; // RL17
                    bus_addr.addr[`BREAKPOINT_REQUEST_PIN_NUM_LSB +: 3] <=
                        (op_kind == OP_HWBK) ? `BREAKPOINT_REQUEST_PIN_HW_NUM : op_breakpoint_request_pin_num; // RL18 RL20
                    bus_addr.addr[`BREAKPOINT_REQUEST_PIN_TBIT] <= (op_kind == OP_HWBK); // RL18 RL20
                end
            end else if (state_ff == ST_GAP) begin
                read_not_write <= 1'b0; // RL11 RL12
            end else if (state_ff == ST_DONE) begin
                indivisible_cycle_flag <= 1'b0; // RL1
                read_not_write         <= 1'b1;
            end
            data_oe_n <= !(writing_ff && (state_ff == ST_S0 || bus_on)); // RL11 RL13
        end
    end

    // ****************************************************************
    // Results and breakpoint tracking
    // ****************************************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_rdata  <= 32'h0;
            op_result <= '0;
        end else if ((state_ff == ST_S2 || state_ff == ST_WAIT) && term_ok) begin
            if (!writing_ff) begin
                op_rdata <= data_in; // RL8
                op_result.port_width <= sync2_ff[1:0]; // RL23
                op_result.opword     <= data_in[31:16]; // RL19
            end
            op_result.bus_err      <= bus_error_in_s;
            op_result.illegal_trap <= bus_error_in_s && (kind_ff == OP_SWBK); // RL19
            op_result.breakpoint_request_pin_trap    <= bus_error_in_s && (kind_ff == OP_HWBK); // RL20
        end else if (state_ff == ST_IDLE && op_start) begin
            op_result <= '0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            breakpoint_request_pin_pending     <= 1'b0;
            breakpoint_request_pin_after_first <= 1'b0;
        end else begin
            if (breakpoint_request_pin_s && (state_ff == ST_S2 || state_ff == ST_WAIT) && term_ok) begin
                breakpoint_request_pin_pending     <= 1'b1; // RL21
                breakpoint_request_pin_after_first <= op_pair_fetch; // RL22
            end else if (state_ff == ST_DONE && kind_ff == OP_HWBK) begin
                breakpoint_request_pin_pending     <= 1'b0; // RL21
                breakpoint_request_pin_after_first <= 1'b0;
            end
        end
    end

    assign op_busy       = (state_ff != ST_IDLE);
    assign op_done       = (state_ff == ST_DONE);
    assign bus_grant_out = bus_request_in && !op_busy && !indivisible_cycle_flag; // RL2

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_GRANT_BLOCKED: assert property (@(posedge core_clk) disable iff (!arst_n) // RL2
        indivisible_cycle_flag |-> !bus_grant_out) else $error("Grant during locked sequence.");
    AST_FLAG_HELD: assert property (@(posedge core_clk) disable iff (!arst_n) // RL1
        (indivisible_cycle_flag && state_ff != ST_DONE && state_ff != ST_IDLE)
        |=> indivisible_cycle_flag) else $error("Lock flag dropped early.");
    AST_READ_DIR: assert property (@(posedge core_clk) disable iff (!arst_n) // RL3
        (state_ff == ST_S0 && !writing_ff) |-> read_not_write) else $error("Read not high.");
    AST_READ_STROBES: assert property (@(posedge core_clk) disable iff (!arst_n) // RL4
        (state_ff == ST_S0 && !writing_ff) |=> address_strobe && data_strobe)
        else $error("Read strobes missing in S1.");
    AST_WAIT_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n) // RL6
        (state_ff == ST_S2 && !term_ok) |=> state_ff == ST_WAIT)
        else $error("No wait state inserted.");
    AST_WRITE_DIR: assert property (@(posedge core_clk) disable iff (!arst_n) // RL12
        (state_ff == ST_GAP) |=> !read_not_write) else $error("Write direction not low.");
    AST_WRITE_DRIVE: assert property (@(posedge core_clk) disable iff (!arst_n) // RL13
        (writing_ff && state_ff == ST_S2) |-> !data_oe_n) else $error("Write data not driven.");
    AST_IDLE_UNDRIVEN: assert property (@(posedge core_clk) disable iff (!arst_n) // RL11
        (state_ff == ST_GAP) |-> data_oe_n && !address_strobe) else $error("Gap drove bus.");
    AST_PSP_FC: assert property (@(posedge core_clk) disable iff (!arst_n) // RL17
        (op_busy && kind_ff != OP_RMW) |-> bus_addr.fc == `FC_PROC_SPACE)
        else $error("Processor-space code wrong.");
    AST_HW_ADDR: assert property (@(posedge core_clk) disable iff (!arst_n) // RL20
        (op_busy && kind_ff == OP_HWBK && state_ff != ST_S0) |->
        bus_addr.addr[`BREAKPOINT_REQUEST_PIN_NUM_LSB +: 3] == `BREAKPOINT_REQUEST_PIN_HW_NUM && bus_addr.addr[`BREAKPOINT_REQUEST_PIN_TBIT])
        else $error("Hardware breakpoint address wrong.");
    AST_SW_ADDR: assert property (@(posedge core_clk) disable iff (!arst_n) // RL18
        (op_busy && kind_ff == OP_SWBK && state_ff != ST_S0) |->
        !bus_addr.addr[`BREAKPOINT_REQUEST_PIN_TBIT] && bus_addr.size == `SIZE_WORD)
        else $error("Software breakpoint address wrong.");
    AST_STROBES_DROP: assert property (@(posedge core_clk) disable iff (!arst_n) // RL8
        ((state_ff == ST_S2 || state_ff == ST_WAIT) && term_ok) |=>
        !address_strobe && !data_strobe) else $error("Strobes not negated after end.");
    AST_BUSY_NO_GRANT: assert property (@(posedge core_clk) disable iff (!arst_n) // RL2
        op_busy |-> !bus_grant_out) else $error("Grant while sequencer busy.");
    AST_BUS_ERROR_IN_ENDS: assert property (@(posedge core_clk) disable iff (!arst_n) // RL11
        (state_ff == ST_S4 && bus_error_in_s) |=> state_ff == ST_DONE)
        else $error("Sequence continued after bus error.");
endmodule // rmw_breakpoint_request_pin_seq

// File: bench/bus_responder.sv
// Responding memory on the far side of the sequencer's external bus.
// Assumes one clock, strobes active high and a 32-bit port.
module bus_responder
    import rmw_breakpoint_request_pin_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        address_strobe,
    input  wire logic        data_strobe,
    input  wire logic        read_not_write,
    input  wire logic        data_oe_n,
    input  wire logic [31:0] data_out,
    input  wire logic [3:0]  wait_cycles,
    input  wire logic        use_bus_error_in,
    input  wire logic [31:0] rd_word,
    output logic             transfer_ack_high,
    output logic             transfer_ack_low,
    output logic             bus_error_in,
    output logic [31:0]      data_in,
    output logic [31:0]      wr_word,
    output logic [3:0]       n_writes
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt;

    // Released data lines are inverted every clock, so a stale value shows again only on alternate clocks.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 4'h0;
            {transfer_ack_high, transfer_ack_low, bus_error_in} <= 3'h0;
            data_in <= 32'h0;
            wr_word <= 32'h0;
            n_writes <= 4'h0;
        end else if (address_strobe) begin
            cnt <= cnt + 4'h1;
            if (cnt >= wait_cycles) begin
                {transfer_ack_high, transfer_ack_low} <= {2{!use_bus_error_in}};
                bus_error_in <= use_bus_error_in;
            end
            if (read_not_write) begin
                data_in <= rd_word;
            end else if (data_strobe && !data_oe_n) begin
                wr_word <= data_out;
            end
            if (cnt == 4'h0 && !read_not_write) begin
                n_writes <= n_writes + 4'h1;
            end
        end else begin
            cnt <= 4'h0;
            {transfer_ack_high, transfer_ack_low, bus_error_in} <= 3'h0;
            data_in <= ~data_in;
        end
    end
endmodule // bus_responder

// File: bench/testbench.sv
// Self-checking bench for the indivisible-cycle and breakpoint sequencer.
// Assumes the package, the defines header and bus_responder are compiled first.
`include "rmw_breakpoint_request_pin_defines.svh"
module testbench
    import rmw_breakpoint_request_pin_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, arst_n = 1'b0, op_start = 1'b0, op_pair_fetch = 1'b0;
    op_kind_t op_kind = OP_RMW;
    bus_addr_t op_addr = '0, bus_addr, rd_addr = '0;
    bus_result_t op_result;
    logic [31:0] op_wdata = 32'h0, op_rdata, data_in, data_out, wr_word, rd_word = 32'h0;
    logic [2:0] op_reads = 3'h1, op_writes = 3'h0, op_breakpoint_request_pin_num = 3'h0;
    logic [3:0] wait_cycles = 4'h0, n_writes;
    logic bus_request_in = 1'b0, breakpoint_request_pin = 1'b0, use_bus_error_in = 1'b0;
    logic transfer_ack_high, transfer_ack_low, bus_error_in, op_busy, op_done;
    logic bus_grant_out, indivisible_cycle_flag, address_strobe, data_strobe;
    logic read_not_write, data_oe_n, breakpoint_request_pin_pending, breakpoint_request_pin_after_first;
    logic flag_gap = 1'b0, grant_seen = 1'b0, oe_clash = 1'b0, split = 1'b0;
    int n_mismatch = 0, num_checks = 0;

    always #4 core_clk = ~core_clk;

    rmw_breakpoint_request_pin_seq dut (.core_clk(core_clk), .arst_n(arst_n), .op_start(op_start),
        .op_kind(op_kind), .op_addr(op_addr), .op_wdata(op_wdata), .op_reads(op_reads),
        .op_writes(op_writes), .op_breakpoint_request_pin_num(op_breakpoint_request_pin_num), .op_pair_fetch(op_pair_fetch),
        .bus_request_in(bus_request_in), .transfer_ack_high(transfer_ack_high),
        .transfer_ack_low(transfer_ack_low), .bus_error_in(bus_error_in),
        .breakpoint_request_pin(breakpoint_request_pin), .data_in(data_in),
        .op_busy(op_busy), .op_done(op_done), .op_result(op_result), .op_rdata(op_rdata),
        .breakpoint_request_pin_pending(breakpoint_request_pin_pending), .breakpoint_request_pin_after_first(breakpoint_request_pin_after_first),
        .bus_grant_out(bus_grant_out),
        .indivisible_cycle_flag(indivisible_cycle_flag), .address_strobe(address_strobe),
        .data_strobe(data_strobe), .read_not_write(read_not_write), .bus_addr(bus_addr),
        .data_out(data_out), .data_oe_n(data_oe_n));

    bus_responder mem (.core_clk(core_clk), .arst_n(arst_n), .address_strobe(address_strobe),
        .data_strobe(data_strobe), .read_not_write(read_not_write), .data_oe_n(data_oe_n),
        .data_out(data_out), .wait_cycles(wait_cycles), .use_bus_error_in(use_bus_error_in),
        .rd_word(rd_word), .transfer_ack_high(transfer_ack_high),
        .transfer_ack_low(transfer_ack_low), .bus_error_in(bus_error_in),
        .data_in(data_in), .wr_word(wr_word), .n_writes(n_writes));

    // ****************************************************************
    // Bus watcher and shared tasks.
    // ****************************************************************
    always @(negedge core_clk) begin
        if (op_busy) begin
            if (address_strobe && !indivisible_cycle_flag && op_kind == OP_RMW) flag_gap = 1'b1;
            if (bus_grant_out) grant_seen = 1'b1;
            if (!data_oe_n && read_not_write) oe_clash = 1'b1;
            if (address_strobe && read_not_write) begin
                rd_addr = bus_addr;
                if (!data_strobe) split = 1'b1;
            end
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic run_op(input op_kind_t k, input logic [2:0] nr, input logic [2:0] nw,
                          input logic [3:0] wc, input logic be);
        int i;
        @(posedge core_clk);
        {flag_gap, grant_seen, oe_clash, split} = 4'h0;
        op_kind <= k;
        op_reads <= nr;
        op_writes <= nw;
        wait_cycles <= wc;
        use_bus_error_in <= be;
        op_start <= 1'b1;
        @(posedge core_clk);
        op_start <= 1'b0;
        for (i = 0; i < 300 && op_done !== 1'b1; i++) @(negedge core_clk);
        if (op_done !== 1'b1) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, op_done, 1'b1);
            end_of_test;
        end
        @(negedge core_clk);
        @(negedge core_clk);
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_rmw_lock;
        op_addr <= '{addr: 32'h0004_1236, fc: 4'h5, size: 2'h0};
        op_wdata <= 32'hA5A5_5A5A;
        rd_word <= 32'h1357_9BDF;
        bus_request_in <= 1'b1;
        run_op(OP_RMW, 3'h1, 3'h1, 4'h0, 1'b0);
        chk(32'(flag_gap), 32'h0);
        chk(32'(grant_seen), 32'h0);
        chk(32'(bus_grant_out), 32'h1);
        chk(rd_addr.addr, 32'h0004_1236);
        chk(32'({rd_addr.fc, rd_addr.size}), 32'h14);
        chk(32'(split), 32'h0);
        chk(op_rdata, 32'h1357_9BDF);
        chk(32'(oe_clash), 32'h0);
        chk(wr_word, 32'hA5A5_5A5A);
        chk(32'(n_writes), 32'h1);
        bus_request_in <= 1'b0;
        $display("test rmw_lock done");
    endtask

    task automatic t_rmw_waits;
        rd_word <= 32'hC0DE_0042;
        run_op(OP_RMW, 3'h2, 3'h2, 4'h3, 1'b0);
        chk(op_rdata, 32'hC0DE_0042);
        chk(32'(n_writes), 32'h3);
        chk(32'(flag_gap), 32'h0);
        run_op(OP_RMW, 3'h2, 3'h0, 4'h5, 1'b0);
        chk(32'(n_writes), 32'h3);
        $display("test rmw_waits done");
    endtask

    task automatic t_soft_breakpoint_request_pin;
        int n;
        rd_word <= 32'h4E71_FFFF;
        for (n = 0; n < 8; n++) begin
            op_breakpoint_request_pin_num <= 3'(n);
            run_op(OP_SWBK, 3'h1, 3'h0, 4'(n), 1'b0);
            chk(32'(rd_addr.fc), 32'(`FC_PROC_SPACE));
            chk(32'(rd_addr.addr[19:16]), 32'(`PSP_TYPE_BREAKPOINT_REQUEST_PIN));
            chk(32'({rd_addr.addr[4:1], rd_addr.size}), 32'({3'(n), 1'b0, `SIZE_WORD}));
            chk(32'({op_result.illegal_trap, op_result.opword}), 32'h4E71);
        end
        run_op(OP_SWBK, 3'h1, 3'h0, 4'h1, 1'b1);
        chk(32'({op_result.bus_err, op_result.illegal_trap}), 32'h3);
        $display("test soft_breakpoint_request_pin done");
    endtask

    task automatic t_hard_breakpoint_request_pin;
        breakpoint_request_pin <= 1'b1;
        op_pair_fetch <= 1'b1;
        op_breakpoint_request_pin_num <= 3'h2;
        run_op(OP_SWBK, 3'h1, 3'h0, 4'h1, 1'b0);
        chk(32'({breakpoint_request_pin_pending, breakpoint_request_pin_after_first}), 32'h3);
        run_op(OP_HWBK, 3'h1, 3'h0, 4'h2, 1'b1);
        chk(32'(rd_addr.addr[4:1]), 32'hF);
        chk(32'(op_result.breakpoint_request_pin_trap), 32'h1);
        chk(32'({breakpoint_request_pin_pending, breakpoint_request_pin_after_first}), 32'h0);
        breakpoint_request_pin <= 1'b0;
        run_op(OP_HWBK, 3'h1, 3'h0, 4'h0, 1'b0);
        chk(32'({op_result.breakpoint_request_pin_trap, op_result.illegal_trap}), 32'h0);
        op_pair_fetch <= 1'b0;
        $display("test hard_breakpoint_request_pin done");
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_rmw_lock();
        t_rmw_waits();
        t_soft_breakpoint_request_pin();
        t_hard_breakpoint_request_pin();
        end_of_test();
    end
endmodule // testbench
